//--- rms_pkg.sv
// shared constants for the readout mode select block
package rms_pkg;

   // sampling (correlated sampling) modes, internal encoding
   typedef enum logic [1:0] {
      RMS_SMP_FULL,
      RMS_SMP_QUASI,
      RMS_SMP_NONE,
      RMS_SMP_XFER
   } rms_smp_e;

   // pin codes for sampling mode, written {msb, lsb}
   localparam logic [1:0] RMS_PIN_SMP_FULL = 2'h0;
   localparam logic [1:0] RMS_PIN_SMP_QUASI = 2'h2;
   localparam logic [1:0] RMS_PIN_SMP_NONE = 2'h1;
   localparam logic [1:0] RMS_PIN_SMP_XFER = 2'h3;

   // row binning: log2 of rows per output row
   localparam logic [1:0] RMS_BIN_X1 = 2'h0;
   localparam logic [1:0] RMS_BIN_X2 = 2'h1;
   localparam logic [1:0] RMS_BIN_X4 = 2'h2;

   // register byte offsets
   localparam logic [11:0] RMS_CFG_OFS = 12'h000;
   localparam logic [11:0] RMS_STAT_OFS = 12'h004;

   // config register fields and reset value
   localparam int RMS_CFG_SMP_LSB = 0;
   localparam int RMS_CFG_BIN_LSB = 2;
   localparam logic [3:0] RMS_CFG_RST = 4'h0;

   // status register field positions
   localparam int RMS_STAT_SMP_LSB = 0;
   localparam int RMS_STAT_BIN_LSB = 2;
   localparam int RMS_STAT_MST_BIT = 4;
   localparam int RMS_STAT_ANA_BIT = 5;
   localparam int RMS_STAT_SPR_LSB = 6;

   // apb address width seen by the block
   localparam int RMS_ADDR_W = 12;

endpackage : rms_pkg

//--- rms_mode_decode.sv
`timescale 1ns/10ps
`default_nettype none

// selects between pin fields and register fields, then decodes them
module rms_mode_decode
   import rms_pkg::*;
(
   input wire logic master_mode,
   input wire logic [1:0] pin_smp,
   input wire logic [1:0] pin_bin,
   input wire logic [1:0] cfg_smp,
   input wire logic [1:0] cfg_bin,
   output logic [1:0] smp_mode,
   output logic [1:0] bin_shift
);

   // pin sampling field {msb, lsb} to internal mode
   function automatic logic [1:0] rms_smp_dec(input logic [1:0] code);
      logic [1:0] m;
      m = RMS_SMP_FULL;
      unique case (code)
         RMS_PIN_SMP_FULL: m = RMS_SMP_FULL;
         RMS_PIN_SMP_QUASI: m = RMS_SMP_QUASI;
         RMS_PIN_SMP_NONE: m = RMS_SMP_NONE;
         RMS_PIN_SMP_XFER: m = RMS_SMP_XFER;
      endcase
      return m;
   endfunction : rms_smp_dec

   // binning field {msb, lsb}: msb set means four rows whatever lsb
   function automatic logic [1:0] rms_bin_dec(input logic [1:0] code);
      return code[1] ? RMS_BIN_X4 : (code[0] ? RMS_BIN_X2 : RMS_BIN_X1);
   endfunction : rms_bin_dec

   wire [1:0] sel_smp;
   wire [1:0] sel_bin;

   // master mode uses the register copy, slave mode the pins
   assign sel_smp = master_mode ? cfg_smp : pin_smp;
   assign sel_bin = master_mode ? cfg_bin : pin_bin;
   assign smp_mode = rms_smp_dec(sel_smp);
   assign bin_shift = rms_bin_dec(sel_bin);

endmodule : rms_mode_decode

`default_nettype wire

//--- rms_top.sv
`timescale 1ns/10ps
`default_nettype none

module rms_top
   import rms_pkg::*;
#(
   parameter int PIX_W = 10
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [RMS_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic master_select,
   input wire logic analog_passthrough_select,
   input wire logic sampling_mode_msb,
   input wire logic sampling_mode_lsb,
   input wire logic row_bin_msb,
   input wire logic row_bin_lsb,
   input wire logic spare_input_hi,
   input wire logic spare_input_lo,
   input wire logic [PIX_W-1:0] analog_in_data,
   input wire logic [PIX_W-1:0] video_in_data,
   output logic [PIX_W-1:0] pixel_out_data,
   output logic [1:0] sampling_mode,
   output logic [1:0] row_bin_shift,
   output logic master_mode
);

   // flops
   logic [3:0] cfg_ff;
   logic [PIX_W-1:0] pix_ff;
   logic [1:0] smp_ff;
   logic [1:0] bin_ff;
   logic mst_ff;
   logic ana_ff;
   logic [1:0] spr_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   // next values
   logic [3:0] nxt_cfg;
   logic [PIX_W-1:0] nxt_pix;
   logic nxt_pready;
   logic nxt_pslverr;
   logic [31:0] nxt_prdata;

   // decoded mode fields
   logic [1:0] dec_smp;
   logic [1:0] dec_bin;

   // bus decode
   wire setup_phase;
   wire access_done;
   wire hit_cfg;
   wire hit_stat;
   wire wr_cfg;
   wire [31:0] cfg_word;
   wire [31:0] stat_word;
   wire [1:0] pin_smp;
   wire [1:0] pin_bin;

   // pin fields are gathered msb first
   assign pin_smp = {sampling_mode_msb, sampling_mode_lsb};
   assign pin_bin = {row_bin_msb, row_bin_lsb};

   // mode select from pins or registers
   rms_mode_decode i_rms_mode_decode (
      .master_mode(master_select),
      .pin_smp(pin_smp),
      .pin_bin(pin_bin),
      .cfg_smp(cfg_ff[RMS_CFG_SMP_LSB +: 2]),
      .cfg_bin(cfg_ff[RMS_CFG_BIN_LSB +: 2]),
      .smp_mode(dec_smp),
      .bin_shift(dec_bin)
   );

   // output path choice
   assign nxt_pix = analog_passthrough_select ? analog_in_data : video_in_data;

   // apb address decode; answer comes in the first access cycle
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_ff;
   assign hit_cfg = (paddr == RMS_CFG_OFS);
   assign hit_stat = (paddr == RMS_STAT_OFS);
   assign wr_cfg = access_done & pwrite & hit_cfg & ~pslverr_ff;
   assign cfg_word = {28'h0000000, cfg_ff};
   assign stat_word = {24'h000000, spr_ff, ana_ff, mst_ff, bin_ff, smp_ff};

   // register write, bus answer
   assign nxt_cfg = wr_cfg ? pwdata[3:0] : cfg_ff;
   assign nxt_pready = setup_phase;
   assign nxt_pslverr = setup_phase & ~(hit_cfg | (hit_stat & ~pwrite));
   assign nxt_prdata = (setup_phase & ~pwrite & hit_cfg) ? cfg_word :
                       (setup_phase & ~pwrite & hit_stat) ? stat_word : 32'h00000000;

   // configuration register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_ff <= RMS_CFG_RST;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
      end
   end

   // ready pulse, one cycle after the setup edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= nxt_pready;
      end
   end

   // error flag, standing with ready only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pslverr_ff <= nxt_pslverr;
      end
   end

   // read word, zero outside the answer cycle so a stale word never leaks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h00000000;
      end
      else
      begin
         prdata_ff <= nxt_prdata;
      end
   end

   // selected pixel word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pix_ff <= '0;
      end
      else
      begin
         pix_ff <= nxt_pix;
      end
   end

   // decoded mode fields, one cycle behind the pins or the register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         smp_ff <= RMS_SMP_FULL;
         bin_ff <= RMS_BIN_X1;
      end
      else
      begin
         smp_ff <= dec_smp;
         bin_ff <= dec_bin;
      end
   end

   // raw pin copies shown in the status word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mst_ff <= 1'b0;
         ana_ff <= 1'b0;
         spr_ff <= 2'h0;
      end
      else
      begin
         mst_ff <= master_select;
         ana_ff <= analog_passthrough_select;
         spr_ff <= {spare_input_hi, spare_input_lo};
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pixel_out_data = pix_ff;
   assign sampling_mode = smp_ff;
   assign row_bin_shift = bin_ff;
   assign master_mode = mst_ff;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_PASS_ANALOG: assert property (
      analog_passthrough_select |=> pixel_out_data == $past(analog_in_data))
      else $error("analog data not routed out");

   AST_PASS_VIDEO: assert property (
      !analog_passthrough_select |=> pixel_out_data == $past(video_in_data))
      else $error("video data not routed out");

   // slave mode: every pin code reaches the decoded outputs
   AST_SLAVE_SMP_FULL: assert property (
      !master_select && !sampling_mode_lsb && !sampling_mode_msb |=> sampling_mode == RMS_SMP_FULL)
      else $error("slave pins lsb0 msb0 not full sampling");

   AST_SLAVE_SMP_QUASI: assert property (
      !master_select && !sampling_mode_lsb && sampling_mode_msb |=> sampling_mode == RMS_SMP_QUASI)
      else $error("slave pins lsb0 msb1 not quasi sampling");

   AST_SLAVE_SMP_NONE: assert property (
      !master_select && sampling_mode_lsb && !sampling_mode_msb |=> sampling_mode == RMS_SMP_NONE)
      else $error("slave pins lsb1 msb0 not no-sampling");

   AST_SLAVE_SMP_XFER: assert property (
      !master_select && sampling_mode_lsb && sampling_mode_msb |=> sampling_mode == RMS_SMP_XFER)
      else $error("slave pins lsb1 msb1 not transfer mode");

   AST_SLAVE_SMP_EDGE: assert property (
      !master_select && !sampling_mode_lsb && !sampling_mode_msb ##1
      !master_select && sampling_mode_lsb && sampling_mode_msb
      |=> $past(sampling_mode) == RMS_SMP_FULL && sampling_mode == RMS_SMP_XFER)
      else $error("full to transfer mode change missed");

   AST_SLAVE_BIN2: assert property (
      !master_select && !row_bin_msb && row_bin_lsb |=> row_bin_shift == RMS_BIN_X2)
      else $error("slave binning 01 not two rows");

   AST_BIN_MSB: assert property (
      !master_select && row_bin_msb |=> row_bin_shift == RMS_BIN_X4 && master_mode == 1'b0)
      else $error("binning msb set not four rows");

   AST_BIN_FULL: assert property (
      !master_select && !row_bin_msb && !row_bin_lsb |=> row_bin_shift == RMS_BIN_X1)
      else $error("binning 00 not full resolution");

   AST_MASTER_FLAG: assert property (
      master_select |=> master_mode)
      else $error("master mode flag does not follow select");

   AST_SLAVE_FLAG: assert property (
      !master_select |=> !master_mode)
      else $error("master mode flag set while slave selected");

   // master mode: the config fields drive the decoded outputs
   AST_MASTER_CFG: assert property (
      master_select && cfg_ff[RMS_CFG_SMP_LSB +: 2] == RMS_PIN_SMP_QUASI |=> sampling_mode == RMS_SMP_QUASI)
      else $error("master mode not using config sampling field");

   AST_MASTER_CFG_BIN: assert property (
      master_select && cfg_ff[RMS_CFG_BIN_LSB +: 2] == 2'h1 |=> row_bin_shift == RMS_BIN_X2)
      else $error("master mode not using config binning field");

   AST_MASTER_IGNORE: assert property (
      master_select && $past(master_select) && $stable(cfg_ff) && !$stable(pin_smp)
      |=> $stable(sampling_mode))
      else $error("master mode reacted to sampling pins");

   AST_APB_ANSWER: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");

   // bus: refused accesses, write landing, idle read data
   AST_APB_REFUSE: assert property (
      psel && !penable && !(paddr == RMS_CFG_OFS || (paddr == RMS_STAT_OFS && !pwrite)) |=> pready && pslverr)
      else $error("refused apb access not flagged");

   AST_APB_WRITE: assert property (
      psel && penable && pready && pwrite && paddr == RMS_CFG_OFS |=> cfg_ff == $past(pwdata[3:0]))
      else $error("config write did not land");

   AST_APB_IDLE_DATA: assert property (
      !pready |-> prdata == 32'h00000000)
      else $error("read data not zero outside answer cycle");

   AST_APB_ERR_PAIR: assert property (
      pslverr |-> pready)
      else $error("error flag without ready");

   COV_SLAVE_XFER: cover property (!master_select && sampling_mode_lsb && sampling_mode_msb ##1
      sampling_mode == RMS_SMP_XFER);
   COV_MASTER_WRITE: cover property (wr_cfg && master_select);
   COV_PASS_SWITCH: cover property ($rose(analog_passthrough_select));
   COV_BAD_ADDR: cover property (pready && pslverr);
   COV_MASTER_PIN_CHANGE: cover property (master_select && $past(master_select) && !$stable(pin_smp));

endmodule : rms_top

`default_nettype wire

//--- rms_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

// camera controller model: owns the mode-select pins of the sensor
module rms_ctrl_model
(
   input wire logic pclk,
   output var logic master_select,
   output var logic analog_passthrough_select,
   output var logic sampling_mode_msb,
   output var logic sampling_mode_lsb,
   output var logic row_bin_msb,
   output var logic row_bin_lsb,
   output var logic spare_input_hi,
   output var logic spare_input_lo
);
   // pins start in slave mode with every field at zero
   initial
   begin
      {master_select, analog_passthrough_select} = 2'h0;
      {sampling_mode_msb, sampling_mode_lsb, row_bin_msb, row_bin_lsb} = 4'h0;
      {spare_input_hi, spare_input_lo} = 2'h0;
   end

   // drives a whole pin set just after a rising edge, both bits of a field together
   task automatic drive(input logic ms, input logic ana, input logic [1:0] smp, input logic [1:0] bin,
      input logic [1:0] spr);
   begin
      @(posedge pclk);
      master_select <= ms;
      analog_passthrough_select <= ana;
      {sampling_mode_msb, sampling_mode_lsb} <= smp;
      {row_bin_msb, row_bin_lsb} <= bin;
      {spare_input_hi, spare_input_lo} <= spr;
   end
   endtask : drive
endmodule : rms_ctrl_model

`default_nettype wire

//--- readout_mode_select_inputs_bench.sv
`timescale 1ns/10ps
`default_nettype none

module readout_mode_select_inputs_bench
   import rms_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, master_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] analog_in_data, video_in_data, pixel_out_data;
   logic [1:0] sampling_mode, row_bin_shift;
   wire logic master_select, analog_passthrough_select, sampling_mode_msb, sampling_mode_lsb;
   wire logic row_bin_msb, row_bin_lsb, spare_input_hi, spare_input_lo;
   int n_mismatch = 0;
   int n_compared = 0;

   rms_top #(.PIX_W(10)) i_rms_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .master_select, .analog_passthrough_select, .sampling_mode_msb, .sampling_mode_lsb,
      .row_bin_msb, .row_bin_lsb, .spare_input_hi, .spare_input_lo, .analog_in_data, .video_in_data,
      .pixel_out_data, .sampling_mode, .row_bin_shift, .master_mode);
   rms_ctrl_model i_rms_ctrl_model (.pclk, .master_select, .analog_passthrough_select, .sampling_mode_msb,
      .sampling_mode_lsb, .row_bin_msb, .row_bin_lsb, .spare_input_hi, .spare_input_lo);

   // 125 MHz clock
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask : check

   task automatic report_and_stop;
   begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask : report_and_stop

   // one apb transfer; the answer is taken at the very edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
   begin
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, addr, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      if (n >= 20)
         check("pready wait", 32'h0, 32'h1);
   end
   endtask : apb

   // outputs follow pins at the very edge that samples them; settle waits one edge more
   task automatic settle;
   begin
      repeat (2) @(posedge pclk);
      #1;
   end
   endtask : settle

   // every sampling and binning pin code in slave mode
   task automatic t_slave;
      logic [1:0] es [4];
      logic [1:0] eb [4];
   begin
      es = '{2'h0, 2'h2, 2'h1, 2'h3};
      eb = '{2'h0, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 4; i++)
      begin
         i_rms_ctrl_model.drive(1'b0, 1'b0, 2'(i), 2'(i), 2'h0);
         settle();
         check("sampling_mode", 32'(sampling_mode), 32'(es[i]));
         check("row_bin_shift", 32'(row_bin_shift), 32'(eb[i]));
         check("master_mode", 32'(master_mode), 32'h0);
      end
   end
   endtask : t_slave

   // config register wins in master mode, pins win again in slave mode
   task automatic t_master;
   begin
      apb(1'b1, RMS_CFG_OFS, 32'h0000_0006);
      check("cfg write err", 32'(err), 32'h0);
      i_rms_ctrl_model.drive(1'b1, 1'b0, 2'h0, 2'h2, 2'h0);
      settle();
      check("master_mode", 32'(master_mode), 32'h1);
      check("master sampling", 32'(sampling_mode), 32'h1);
      check("master binning", 32'(row_bin_shift), 32'h1);
      i_rms_ctrl_model.drive(1'b1, 1'b0, 2'h3, 2'h1, 2'h0);
      settle();
      check("master ignores pins", 32'({sampling_mode, row_bin_shift}), 32'h5);
      apb(1'b0, RMS_CFG_OFS, 32'h0);
      check("cfg readback", rd, 32'h0000_0006);
      i_rms_ctrl_model.drive(1'b0, 1'b0, 2'h0, 2'h2, 2'h0);
      settle();
      check("slave sampling", 32'(sampling_mode), 32'h0);
      check("slave binning", 32'(row_bin_shift), 32'h2);
   end
   endtask : t_master

   // output routing, status word and refused accesses
   task automatic t_regs;
   begin
      i_rms_ctrl_model.drive(1'b0, 1'b1, 2'h3, 2'h1, 2'h2);
      settle();
      check("pixel analog", 32'(pixel_out_data), 32'h0000_02A5);
      apb(1'b0, RMS_STAT_OFS, 32'h0);
      check("status", rd, 32'h0000_00A7);
      i_rms_ctrl_model.drive(1'b0, 1'b0, 2'h3, 2'h1, 2'h2);
      settle();
      check("pixel video", 32'(pixel_out_data), 32'h0000_015A);
      apb(1'b0, 12'h008, 32'h0);
      check("unmapped data", rd, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      apb(1'b1, RMS_STAT_OFS, 32'h0000_00FF);
      check("status write err", 32'(err), 32'h1);
      apb(1'b1, 12'h00C, 32'h0000_000F);
      check("unmapped write err", 32'(err), 32'h1);
      apb(1'b0, RMS_CFG_OFS, 32'h0);
      check("cfg untouched", rd, 32'h0000_0006);
   end
   endtask : t_regs

   // reset in mid-run clears every output and the config register
   task automatic t_reset;
   begin
      @(posedge pclk);
      presetn <= 1'b0;
      #1;
      check("reset mode", 32'({sampling_mode, row_bin_shift, master_mode}), 32'h0);
      check("reset pixel", 32'({pixel_out_data, pready, pslverr}), 32'h0);
      check("reset prdata", prdata, 32'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RMS_CFG_OFS, 32'h0);
      check("cfg after reset", rd, 32'h0);
      check("sampling after reset", 32'(sampling_mode), 32'h3);
   end
   endtask : t_reset

   // watchdog for a hung handshake
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      report_and_stop();
   end

   // reset, then the scenarios
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      analog_in_data = 10'h2A5;
      video_in_data = 10'h15A;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RMS_CFG_OFS, 32'h0);
      check("cfg reset", rd, 32'h0);
      t_slave();
      t_master();
      t_regs();
      t_reset();
      report_and_stop();
   end
endmodule : readout_mode_select_inputs_bench

`default_nettype wire
